// >>> hdl/pcg_pkg.sv
/*
 * Shared constants of the clock generator control: register map of the
 * generator end, field positions, reset values, lock detector figures and
 * the map of the controller end.
 * Assumes one 40 MHz core clock for both ends.
 */
package pcg_pkg;
	// ==========================================================
	// Bus shape
	localparam int AW = 2; // Register address width
	localparam int DW = 8; // Register data width
	// ==========================================================
	// Generator register offsets
	localparam logic [1:0] REG_CTRL = 2'h0; // synth_control_reg
	localparam logic [1:0] REG_BWC = 2'h1; // bandwidth_control_reg
	localparam logic [1:0] REG_PROG = 2'h2; // Multiplier and range factor
	// Bit positions
	localparam int CTRL_ON = 0; // synth_enable
	localparam int CTRL_BCS = 1; // base_source_select
	localparam int CTRL_IE = 2; // lock_change_irq_enable
	localparam int CTRL_PEND = 3; // Lock change pending, write one clears
	localparam int BWC_AUTO = 0; // Automatic bandwidth mode
	localparam int BWC_LOCK = 1; // Lock flag
	localparam int BWC_TRK = 2; // tracking_select
	localparam int PROG_N_LSB = 4; // Multiplier N
	localparam int PROG_L_LSB = 0; // range_factor_field
	localparam int FW = 4; // Width of N and L
	// Reset values
	localparam logic [7:0] PROG_RST = 8'h00;
	localparam logic [3:0] N_ONE = 4'h1; // N of zero acts as one
	// ==========================================================
	// Loop figures
	localparam logic [31:0] FNOM_HZ = 32'h004b_0000; // 4.9152 MHz
	localparam logic [1:0] HOLD_EDGES = 2'h3; // Edges of each clock in stasis
	localparam logic [7:0] LOCK_WIN = 8'h10; // Reference ticks per window
	localparam logic [7:0] TRK_TOL = 8'h01; // Enter tracking
	localparam logic [7:0] UNT_TOL = 8'h02; // Leave tracking
	localparam logic [7:0] LOCK_TOL = 8'h00; // Enter lock
	localparam logic [7:0] UNL_TOL = 8'h01; // Leave lock
	// ==========================================================
	// Controller map
	localparam logic [1:0] H_TARGET = 2'h0; // Generator address to use
	localparam logic [1:0] H_WDATA = 2'h1; // Write forwards a write
	localparam logic [1:0] H_RDATA = 2'h2; // Write starts read, read gives data
	localparam logic [1:0] H_STAT = 2'h3; // Status and oscillator enable
	localparam int ST_OSC = 0; // Oscillator enable, read/write
	localparam int ST_REF = 1; // Write refused, write one clears
	localparam int ST_IRQ = 2; // Interrupt line
	localparam int ST_LOCK = 3; // Lock last seen
	localparam int ST_BASE = 4; // Base clock level
	// Software waits
	localparam int CLK_MHZ = 40;
	localparam int TACQ_US = 5; // Acquisition wait
	localparam int TAL_US = 5; // Acquisition to lock wait
	localparam int TACQ_CYC = TACQ_US * CLK_MHZ;
	localparam int TAL_CYC = TAL_US * CLK_MHZ;
	// Base clock switch states
	typedef enum logic {SW_RUN, SW_HOLD} pcg_sw_t;
endpackage

// >>> hdl/pcg_if.sv
/*
 * Link between the clock generator and its controller: register access,
 * interrupt, oscillator enable and the base clock.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
interface pcg_if;
	logic [pcg_pkg::AW-1:0] addr; // Register address
	logic [pcg_pkg::DW-1:0] wdata; // Write data
	logic wr; // Write strobe
	logic rd; // Read strobe
	logic [pcg_pkg::DW-1:0] rdata; // Read data, cycle after rd
	logic irq; // lock_change_irq
	logic osc_en; // oscillator_enable_in
	logic base_clk; // base_clock_out
	modport gen (input addr, wdata, wr, rd, osc_en, output rdata, irq, base_clk);
	modport ctl (output addr, wdata, wr, rd, osc_en, input rdata, irq, base_clk);
endinterface // pcg_if

// >>> hdl/pcg_gen.sv
/*
 * Clock generator control logic: oscillator gating, reference path,
 * feedback divider, phase and lock detection, bandwidth modes, base
 * clock selection with stasis, and its three registers.
 * Assumes crystal and VCO clocks arrive as slow pins sampled here.
 */
// Contract
// - Base clock is selected clock halved
// - Oscillator runs only while enabled
// - Reference clocks follow crystal clock rate
// - Feedback clock is VCO divided by N
// - Center frequency equals L times nominal
// - Phase detector pulses on phase difference
// - Lock detector compares feedback and reference rates
// - Acquisition mode reads tracking select clear
// - Tracking whenever not acquiring or bit set
// - Automatic mode: detector switches filter mode
// - Automatic: tracking bit read-only, hysteresis driven
// - Automatic: lock flag read-only, hysteresis driven
// - Interrupt on every lock toggle if enabled
// - Software picks VCO only after lock
// - Manual: tracking bit writable, sets mode
// - Manual: tracking clear before loop on
// - Manual: wait acquisition time before tracking
// - Manual: wait lock time before VCO select
// - Manual: no lock flag, no interrupt
// - Switch holds output, three edges each
// - Manual forces interrupt enable to zero
// - VCO selected forces loop on
// - Loop off or L zero forces crystal
`timescale 1ns/1ps
module pcg_gen #(
	parameter logic [7:0] WIN = pcg_pkg::LOCK_WIN
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	// Clock pins
	input wire logic CRYSTAL_CLOCK,
	input wire logic VCO_CLOCK,
	// Loop side outputs
	output logic OSC_RUN,
	output logic LOOP_REFERENCE_CLOCK,
	output logic FINAL_REFERENCE_CLOCK,
	output logic VCO_FEEDBACK_CLOCK,
	output logic PHASE_UP,
	output logic PHASE_DN,
	output logic ACQ_MODE,
	output logic [31:0] VCO_CENTER_HZ,
	// Controller link
	pcg_if.gen LNK
);
	// ==========================================================
	// Parameter check
	if (WIN < 8'h04) begin : g_bad_win
		$error("pcg_gen: WIN below 4");
	end

	// ==========================================================
	// Pin sampling
	logic [1:0] pin_w; // {vco, crystal}
	logic [1:0] s1_q, s2_q, s3_q; // Three-stage sampler
	logic [1:0] lvl_q, prev_q; // Accepted level and its past
	logic [1:0] rise_w; // One-cycle rising edges
	assign pin_w = {VCO_CLOCK, CRYSTAL_CLOCK};
	assign rise_w = lvl_q & ~prev_q;

	// Level changes only when stages two and three agree
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			s1_q <= 2'h0;
			s2_q <= 2'h0;
			s3_q <= 2'h0;
			lvl_q <= 2'h0;
			prev_q <= 2'h0;
		end else begin
			s1_q <= pin_w;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
			prev_q <= lvl_q;
		end
	end

	// ==========================================================
	// Registers
	logic on_q, bcs_q, ie_q, pend_q, auto_q, trk_man_q; // Control state
	logic [7:0] prog_q; // N and L
	logic trk_auto_q, lock_q, lock_prev_q; // Detector state
	logic [3:0] n_w, l_w; // Fields
	logic l_nz_w; // L not zero
	logic wr_ctrl_w, wr_bwc_w, wr_prog_w; // Write decodes
	logic trk_w; // Effective tracking mode
	logic lock_chg_w; // Lock flag toggled
	logic [7:0] ctrl_rd_w, bwc_rd_w, mux_w; // Read views
	logic [7:0] rdata_q; // Read data register
	logic osc_q; // Oscillator running
	logic xr_w, vr_w; // Usable crystal and VCO edges

	assign wr_ctrl_w = LNK.wr && LNK.addr == pcg_pkg::REG_CTRL;
	assign wr_bwc_w = LNK.wr && LNK.addr == pcg_pkg::REG_BWC;
	assign wr_prog_w = LNK.wr && LNK.addr == pcg_pkg::REG_PROG;
	assign l_w = prog_q[pcg_pkg::PROG_L_LSB +: pcg_pkg::FW];
	assign n_w = (prog_q[pcg_pkg::PROG_N_LSB +: pcg_pkg::FW] == 4'h0) ? pcg_pkg::N_ONE
		: prog_q[pcg_pkg::PROG_N_LSB +: pcg_pkg::FW];
	assign l_nz_w = l_w != 4'h0;
	assign trk_w = auto_q ? trk_auto_q : trk_man_q;
	assign lock_chg_w = lock_q ^ lock_prev_q;
	assign xr_w = rise_w[0] & osc_q;
	assign vr_w = rise_w[1] & on_q;

	// Read views; acquisition shows the tracking bit clear
	always_comb begin
		ctrl_rd_w = 8'h00;
		ctrl_rd_w[pcg_pkg::CTRL_ON] = on_q;
		ctrl_rd_w[pcg_pkg::CTRL_BCS] = bcs_q;
		ctrl_rd_w[pcg_pkg::CTRL_IE] = ie_q;
		ctrl_rd_w[pcg_pkg::CTRL_PEND] = pend_q;
		bwc_rd_w = 8'h00;
		bwc_rd_w[pcg_pkg::BWC_AUTO] = auto_q;
		bwc_rd_w[pcg_pkg::BWC_LOCK] = lock_q & auto_q;
		bwc_rd_w[pcg_pkg::BWC_TRK] = trk_w;
	end
	assign mux_w = (LNK.addr == pcg_pkg::REG_CTRL) ? ctrl_rd_w
		: (LNK.addr == pcg_pkg::REG_BWC) ? bwc_rd_w
		: (LNK.addr == pcg_pkg::REG_PROG) ? prog_q : 8'h00;

	// Control registers with their forced values
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			on_q <= 1'b0;
			bcs_q <= 1'b0;
			ie_q <= 1'b0;
			auto_q <= 1'b0;
			trk_man_q <= 1'b0;
			prog_q <= pcg_pkg::PROG_RST;
			rdata_q <= 8'h00;
		end else begin
			// Loop cannot drop while VCO drives the base clock
			on_q <= wr_ctrl_w ? (LNK.wdata[pcg_pkg::CTRL_ON] | bcs_q) : on_q;
			// Old loop state used, so on and select never rise together
			bcs_q <= (wr_ctrl_w ? LNK.wdata[pcg_pkg::CTRL_BCS] : bcs_q)
				& on_q & l_nz_w;
			ie_q <= auto_q & (wr_ctrl_w ? LNK.wdata[pcg_pkg::CTRL_IE] : ie_q);
			auto_q <= wr_bwc_w ? LNK.wdata[pcg_pkg::BWC_AUTO] : auto_q;
			// Tracking bit writable only in manual mode
			if (wr_bwc_w && !auto_q) begin
				trk_man_q <= LNK.wdata[pcg_pkg::BWC_TRK];
			end
			// Multiplier frozen while the loop runs
			if (wr_prog_w && !on_q) begin
				prog_q <= LNK.wdata;
			end
			rdata_q <= LNK.rd ? mux_w : 8'h00;
		end
	end

	// Pending flag; a toggle in the clearing cycle wins
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pend_q <= 1'b0;
			lock_prev_q <= 1'b0;
		end else begin
			lock_prev_q <= lock_q;
			// Manual mode drops a pending request so no interrupt stands there
			pend_q <= ((pend_q & ~(wr_ctrl_w & LNK.wdata[pcg_pkg::CTRL_PEND]))
				| (lock_chg_w & ie_q)) & auto_q;
		end
	end

	// ==========================================================
	// Reference path and feedback divider
	logic [3:0] div_q; // VCO edge count
	logic fb_q; // Feedback clock
	logic fb_tick_w; // Feedback edge
	assign fb_tick_w = vr_w && (div_q >= n_w - 4'h1);

	// Crystal buffered twice; feedback high one VCO period in N
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			osc_q <= 1'b0;
			LOOP_REFERENCE_CLOCK <= 1'b0;
			FINAL_REFERENCE_CLOCK <= 1'b0;
			div_q <= 4'h0;
			fb_q <= 1'b0;
			VCO_CENTER_HZ <= 32'h0;
		end else begin
			osc_q <= LNK.osc_en;
			LOOP_REFERENCE_CLOCK <= lvl_q[0] & osc_q;
			FINAL_REFERENCE_CLOCK <= LOOP_REFERENCE_CLOCK;
			if (!on_q) begin
				div_q <= 4'h0;
				fb_q <= 1'b0;
			end else if (vr_w) begin
				div_q <= fb_tick_w ? 4'h0 : div_q + 4'h1;
				fb_q <= fb_tick_w;
			end
			VCO_CENTER_HZ <= {28'h0, l_w} * pcg_pkg::FNOM_HZ;
		end
	end
	assign VCO_FEEDBACK_CLOCK = fb_q;
	assign OSC_RUN = osc_q;

	// ==========================================================
	// Phase detector: leading edge raises its pulse till the other
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			PHASE_UP <= 1'b0;
			PHASE_DN <= 1'b0;
		end else if (!on_q || (xr_w && fb_tick_w)) begin
			PHASE_UP <= 1'b0;
			PHASE_DN <= 1'b0;
		end else if (xr_w) begin
			PHASE_UP <= ~PHASE_DN;
			PHASE_DN <= 1'b0;
		end else if (fb_tick_w) begin
			PHASE_DN <= ~PHASE_UP;
			PHASE_UP <= 1'b0;
		end
	end

	// ==========================================================
	// Lock detector: feedback edges counted over WIN reference edges
	logic [7:0] win_q, cnt_q; // Window and feedback counts
	logic [7:0] tot_w, err_w; // Window total and its error
	logic last_w; // Window closes
	assign tot_w = cnt_q + {7'h0, fb_tick_w};
	assign err_w = (tot_w > WIN) ? tot_w - WIN : WIN - tot_w;
	assign last_w = xr_w && (win_q == WIN - 8'h01);

	// Hysteresis on both flags; manual mode or loop off clears them
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			win_q <= 8'h00;
			cnt_q <= 8'h00;
			trk_auto_q <= 1'b0;
			lock_q <= 1'b0;
		end else if (!on_q || !auto_q) begin
			win_q <= 8'h00;
			cnt_q <= 8'h00;
			trk_auto_q <= 1'b0;
			lock_q <= 1'b0;
		end else if (last_w) begin
			win_q <= 8'h00;
			cnt_q <= 8'h00;
			if (err_w <= pcg_pkg::TRK_TOL) trk_auto_q <= 1'b1;
			else if (err_w > pcg_pkg::UNT_TOL) trk_auto_q <= 1'b0;
			if (err_w <= pcg_pkg::LOCK_TOL) lock_q <= 1'b1;
			else if (err_w > pcg_pkg::UNL_TOL) lock_q <= 1'b0;
		end else begin
			win_q <= xr_w ? win_q + 8'h01 : win_q;
			cnt_q <= tot_w;
		end
	end

	// Filter mode to the analog side
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) ACQ_MODE <= 1'b1;
		else ACQ_MODE <= ~trk_w;
	end

	// ==========================================================
	// Base clock selector
	pcg_pkg::pcg_sw_t st_q; // Switch state
	logic sel_q; // Active source, 1 is VCO
	logic [1:0] hx_q, hv_q; // Edges seen during stasis
	logic base_q; // Halved clock
	logic sel_rise_w; // Edge of active source
	assign sel_rise_w = sel_q ? vr_w : xr_w;

	// Stasis waits on raw edges: a stopped clock would stall the switch
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			st_q <= pcg_pkg::SW_RUN;
			sel_q <= 1'b0;
			hx_q <= 2'h0;
			hv_q <= 2'h0;
			base_q <= 1'b0;
		end else begin
			case (st_q)
				pcg_pkg::SW_RUN: begin
					if (bcs_q != sel_q) begin
						st_q <= pcg_pkg::SW_HOLD;
						hx_q <= 2'h0;
						hv_q <= 2'h0;
					end else if (sel_rise_w) begin
						base_q <= ~base_q;
					end
				end
				pcg_pkg::SW_HOLD: begin
					if (hx_q == pcg_pkg::HOLD_EDGES && hv_q == pcg_pkg::HOLD_EDGES) begin
						sel_q <= bcs_q;
						st_q <= pcg_pkg::SW_RUN;
					end
					if (rise_w[0] && hx_q != pcg_pkg::HOLD_EDGES) hx_q <= hx_q + 2'h1;
					if (rise_w[1] && hv_q != pcg_pkg::HOLD_EDGES) hv_q <= hv_q + 2'h1;
				end
				default: st_q <= pcg_pkg::SW_RUN;
			endcase
		end
	end
	assign LNK.base_clk = base_q;
	assign LNK.rdata = rdata_q;
	assign LNK.irq = pend_q;
endmodule // pcg_gen

// >>> hdl/pcg_ctl.sv
/*
 * Controller end: forwards software accesses to the clock generator,
 * drives the oscillator enable and refuses writes that break the start-up
 * order for the loop.
 * Assumes the generator answers reads one cycle after the strobe.
 */
`timescale 1ns/1ps
module pcg_ctl #(
	parameter int ACQ_WAIT = pcg_pkg::TACQ_CYC,
	parameter int AL_WAIT = pcg_pkg::TAL_CYC
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	// Software port
	input wire logic [1:0] SW_ADDR,
	input wire logic [7:0] SW_WDATA,
	input wire logic SW_WR,
	input wire logic SW_RD,
	output logic [7:0] SW_RDATA,
	// Generator link
	pcg_if.ctl LNK
);
	// ==========================================================
	// Parameter check
	if (ACQ_WAIT < 1 || ACQ_WAIT > 65535 || AL_WAIT < 1 || AL_WAIT > 65535) begin : g_bad
		$error("pcg_ctl: wait out of range");
	end
	localparam logic [15:0] ACQ_C = 16'(ACQ_WAIT);
	localparam logic [15:0] AL_C = 16'(AL_WAIT);

	// ==========================================================
	// State
	logic [1:0] tgt_q, rd_tgt_q; // Target and read target
	logic [7:0] wd_q, rbuf_q; // Last write, last read
	logic osc_q, ref_q, seen_q, rpend_q; // Status
	logic sh_auto_q, sh_on_q, sh_trk_q, sh_bcs_q; // Generator shadow
	logic [15:0] acq_q, al_q; // Wait timers
	logic fwd_w, rdgo_w, ctrl_w, bwc_w, bad_w, stat_w; // Decodes
	logic [7:0] st_w, mux_w; // Read views
	logic w_on, w_bcs, w_auto, w_trk; // Written fields

	assign fwd_w = SW_WR && SW_ADDR == pcg_pkg::H_WDATA;
	assign rdgo_w = SW_WR && SW_ADDR == pcg_pkg::H_RDATA;
	assign stat_w = SW_WR && SW_ADDR == pcg_pkg::H_STAT;
	assign ctrl_w = tgt_q == pcg_pkg::REG_CTRL;
	assign bwc_w = tgt_q == pcg_pkg::REG_BWC;
	assign w_on = SW_WDATA[pcg_pkg::CTRL_ON];
	assign w_bcs = SW_WDATA[pcg_pkg::CTRL_BCS];
	assign w_auto = SW_WDATA[pcg_pkg::BWC_AUTO];
	assign w_trk = SW_WDATA[pcg_pkg::BWC_TRK];
	// Writes that would break the start-up order
	assign bad_w = (ctrl_w && sh_auto_q && w_bcs && !sh_bcs_q && !seen_q)
		|| (ctrl_w && !sh_auto_q && w_on && !sh_on_q && sh_trk_q)
		|| (bwc_w && !w_auto && w_trk && !sh_trk_q && acq_q < ACQ_C)
		|| (ctrl_w && !sh_auto_q && w_bcs && !sh_bcs_q && al_q < AL_C);

	always_comb begin
		st_w = 8'h00;
		st_w[pcg_pkg::ST_OSC] = osc_q;
		st_w[pcg_pkg::ST_REF] = ref_q;
		st_w[pcg_pkg::ST_IRQ] = LNK.irq;
		st_w[pcg_pkg::ST_LOCK] = seen_q;
		st_w[pcg_pkg::ST_BASE] = LNK.base_clk;
	end
	assign mux_w = (SW_ADDR == pcg_pkg::H_TARGET) ? {6'h0, tgt_q}
		: (SW_ADDR == pcg_pkg::H_WDATA) ? wd_q
		: (SW_ADDR == pcg_pkg::H_RDATA) ? rbuf_q : st_w;

	// ==========================================================
	// Forwarding and shadow of the generator state
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tgt_q <= 2'h0;
			wd_q <= 8'h00;
			LNK.addr <= 2'h0;
			LNK.wdata <= 8'h00;
			LNK.wr <= 1'b0;
			LNK.rd <= 1'b0;
			sh_auto_q <= 1'b0;
			sh_on_q <= 1'b0;
			sh_trk_q <= 1'b0;
			sh_bcs_q <= 1'b0;
		end else begin
			LNK.wr <= fwd_w && !bad_w;
			LNK.rd <= rdgo_w;
			if (SW_WR && SW_ADDR == pcg_pkg::H_TARGET) tgt_q <= SW_WDATA[1:0];
			if (fwd_w || rdgo_w) LNK.addr <= tgt_q;
			if (fwd_w) wd_q <= SW_WDATA;
			if (fwd_w && !bad_w) begin
				LNK.wdata <= SW_WDATA;
				if (ctrl_w) begin
					sh_on_q <= w_on | sh_bcs_q;
					sh_bcs_q <= w_bcs & sh_on_q;
				end
				if (bwc_w) begin
					sh_auto_q <= w_auto;
					sh_trk_q <= w_trk & ~w_auto;
				end
			end
		end
	end

	// Timers run from loop on and from tracking entry
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			acq_q <= 16'h0;
			al_q <= 16'h0;
		end else begin
			acq_q <= !sh_on_q ? 16'h0 : (acq_q == 16'hffff ? acq_q : acq_q + 16'h1);
			al_q <= !sh_trk_q ? 16'h0 : (al_q == 16'hffff ? al_q : al_q + 16'h1);
		end
	end

	// Read capture and status; a refusal in the clearing cycle wins
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rpend_q <= 1'b0;
			rd_tgt_q <= 2'h0;
			rbuf_q <= 8'h00;
			seen_q <= 1'b0;
			osc_q <= 1'b0;
			ref_q <= 1'b0;
			SW_RDATA <= 8'h00;
			LNK.osc_en <= 1'b0;
		end else begin
			rpend_q <= LNK.rd; // Answer stands the cycle after the link strobe
			if (rdgo_w) rd_tgt_q <= tgt_q;
			if (rpend_q) begin
				rbuf_q <= LNK.rdata;
				if (rd_tgt_q == pcg_pkg::REG_BWC) seen_q <= LNK.rdata[pcg_pkg::BWC_LOCK];
			end
			if (stat_w) osc_q <= SW_WDATA[pcg_pkg::ST_OSC];
			LNK.osc_en <= stat_w ? SW_WDATA[pcg_pkg::ST_OSC] : osc_q;
			ref_q <= (ref_q & ~(stat_w & SW_WDATA[pcg_pkg::ST_REF])) | (fwd_w & bad_w);
			SW_RDATA <= SW_RD ? mux_w : 8'h00;
		end
	end
endmodule // pcg_ctl

// >>> dv/pcg_sva.sv
/*
 * Checker of the generator link: read answers, forced bits, refusals.
 * Assumes it is instantiated beside the link that joins both ends.
 */
`timescale 1ns/1ps
module pcg_sva #(
	parameter int ACQ_WAIT = 200,
	parameter int AL_WAIT = 200
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	// Link signals
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic irq,
	input wire logic osc_en,
	input wire logic base_clk
);
	// ==========================================================
	// Shadows of what was really forwarded
	logic auto_q, on_q, trk_q, lock_q, bwc_rd_q; // Mirrors of generator bits
	logic [2:0] man_q; // Manual mode history
	int on_cnt_q, trk_cnt_q; // Cycles of loop on, of tracking
	wire wr_ctrl = wr && addr == pcg_pkg::REG_CTRL;
	wire wr_bwc = wr && addr == pcg_pkg::REG_BWC;
	wire sel_w = wdata[pcg_pkg::CTRL_BCS];
	// Shadows follow link writes; lock comes from the last answered bandwidth register read
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			{auto_q, on_q, trk_q, lock_q, bwc_rd_q, man_q} <= '0;
			on_cnt_q <= 0;
			trk_cnt_q <= 0;
		end else begin
			auto_q <= wr_bwc ? wdata[pcg_pkg::BWC_AUTO] : auto_q;
			on_q <= wr_ctrl ? wdata[pcg_pkg::CTRL_ON] | sel_w : on_q;
			trk_q <= wr_bwc ? wdata[pcg_pkg::BWC_TRK] & ~wdata[pcg_pkg::BWC_AUTO] : trk_q;
			bwc_rd_q <= rd && addr == pcg_pkg::REG_BWC;
			lock_q <= bwc_rd_q ? rdata[pcg_pkg::BWC_LOCK] : lock_q;
			man_q <= {man_q[1:0], ~auto_q};
			// Saturate so that long runs never wrap
			on_cnt_q <= on_q ? on_cnt_q + int'(on_cnt_q < 1000) : 0;
			trk_cnt_q <= trk_q ? trk_cnt_q + int'(trk_cnt_q < 1000) : 0;
		end
	end
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (SYS_RST);
	// ==========================================================
	// Assertions; waits allow two cycles of forwarding slack
	a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
		else $error("read data outside its answer cycle");
	a_on_forced: assert property (rd && addr == pcg_pkg::REG_CTRL
		|=> !rdata[pcg_pkg::CTRL_BCS] || rdata[pcg_pkg::CTRL_ON])
		else $error("base select read without loop on");
	a_manual_lock: assert property (rd && addr == pcg_pkg::REG_BWC && !auto_q
		|=> !rdata[pcg_pkg::BWC_LOCK])
		else $error("lock flag shown in manual mode");
	a_manual_irq: assert property (&man_q |-> !irq)
		else $error("interrupt in manual mode");
	a_irq_auto: assert property ($rose(irq) |-> auto_q)
		else $error("interrupt raised outside automatic mode");
	a_vco_lock: assert property (wr_ctrl && sel_w && auto_q |-> lock_q)
		else $error("vco selected before lock was seen");
	a_trk_wait: assert property (wr_bwc && wdata[pcg_pkg::BWC_TRK] && !auto_q
		&& !wdata[pcg_pkg::BWC_AUTO] && on_q && !trk_q |-> on_cnt_q + 2 >= ACQ_WAIT)
		else $error("tracking set too soon after loop on");
	a_vco_wait: assert property (wr_ctrl && sel_w && !auto_q
		|-> trk_q && trk_cnt_q + 2 >= AL_WAIT)
		else $error("vco selected too soon after tracking");
	// Main scenarios
	c_irq: cover property ($rose(irq));
	c_vco_sel: cover property (wr_ctrl && sel_w);
	c_lock_read: cover property (bwc_rd_q && rdata[pcg_pkg::BWC_LOCK]);
	c_base_run: cover property (osc_en && $rose(base_clk));
endmodule // pcg_sva

// >>> dv/pcg_tb.sv
/*
 * Testbench: both ends joined by the link, driven from the software port.
 * Assumes package, link, both ends and checker are compiled first.
 */
`timescale 1ns/1ps
module pcg_tb;
	// ==========================================================
	// Clocks, pins and software port
	localparam int ACQ_W = 40; // Short waits keep the run brief
	localparam int AL_W = 40;
	logic CORE_CLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic xtal = 1'b0; // Crystal pin, 400 ns
	logic vco = 1'b0; // VCO pin; 200 ns locks with N of 2
	logic [1:0] sw_addr = 2'h0;
	logic [7:0] sw_wdata = 8'h00;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	wire [7:0] sw_rdata;
	wire acq_mode;
	wire [31:0] center_hz;
	int error_cnt = 0;
	int checks = 0;
	int vco_half = 100;
	always #12.5 CORE_CLK = ~CORE_CLK;
	always #200 xtal = ~xtal;
	always #(vco_half) vco = ~vco;
	pcg_if lnk ();
	pcg_gen #(.WIN(8'h04)) i_pcg_gen (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
		.CRYSTAL_CLOCK(xtal), .VCO_CLOCK(vco), .OSC_RUN(), .LOOP_REFERENCE_CLOCK(),
		.FINAL_REFERENCE_CLOCK(), .VCO_FEEDBACK_CLOCK(), .PHASE_UP(), .PHASE_DN(),
		.ACQ_MODE(acq_mode), .VCO_CENTER_HZ(center_hz), .LNK(lnk.gen));
	pcg_ctl #(.ACQ_WAIT(ACQ_W), .AL_WAIT(AL_W)) i_pcg_ctl (.CORE_CLK(CORE_CLK),
		.SYS_RST(SYS_RST), .SW_ADDR(sw_addr), .SW_WDATA(sw_wdata), .SW_WR(sw_wr),
		.SW_RD(sw_rd), .SW_RDATA(sw_rdata), .LNK(lnk.ctl));
	pcg_sva #(.ACQ_WAIT(ACQ_W), .AL_WAIT(AL_W)) i_pcg_sva (.CORE_CLK(CORE_CLK),
		.SYS_RST(SYS_RST), .addr(lnk.addr), .wdata(lnk.wdata), .wr(lnk.wr), .rd(lnk.rd),
		.rdata(lnk.rdata), .irq(lnk.irq), .osc_en(lnk.osc_en), .base_clk(lnk.base_clk));
	// ==========================================================
	// Access tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic sw_write(input logic [1:0] a, input logic [7:0] v);
		@(posedge CORE_CLK);
		sw_addr <= a;
		sw_wdata <= v;
		sw_wr <= 1'b1;
		@(posedge CORE_CLK);
		sw_wr <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe
	task automatic sw_read(input logic [1:0] a, output logic [7:0] v);
		@(posedge CORE_CLK);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge CORE_CLK);
		sw_rd <= 1'b0;
		#1 v = sw_rdata;
	endtask
	task automatic gen_write(input logic [1:0] a, input logic [7:0] v);
		sw_write(pcg_pkg::H_TARGET, {6'h00, a});
		sw_write(pcg_pkg::H_WDATA, v);
		repeat (2) @(posedge CORE_CLK);
	endtask
	task automatic gen_read(input logic [1:0] a, output logic [7:0] v);
		sw_write(pcg_pkg::H_TARGET, {6'h00, a});
		sw_write(pcg_pkg::H_RDATA, 8'h00);
		repeat (3) @(posedge CORE_CLK);
		sw_read(pcg_pkg::H_RDATA, v);
	endtask
	task automatic reg_chk(input logic [1:0] a, input logic [7:0] e, input string what);
		logic [7:0] v;
		gen_read(a, v);
		chk(what, {24'h0, e}, {24'h0, v});
	endtask
	// Base clock level bit masked off
	task automatic stat_chk(input logic [7:0] e, input string what);
		logic [7:0] v;
		sw_read(pcg_pkg::H_STAT, v);
		chk(what, {24'h0, e}, {24'h0, v & 8'h0f});
	endtask
	task automatic wait_lock(input logic want);
		logic [7:0] v;
		for (int i = 0; i < 80; i++) begin
			gen_read(pcg_pkg::REG_BWC, v);
			if (v[pcg_pkg::BWC_LOCK] === want) break;
		end
		chk("lock flag", {31'h0, want}, {31'h0, v[pcg_pkg::BWC_LOCK]});
	endtask
	// Edges of the base clock over 128 cycles
	task automatic tog_chk(input int lo, input int hi, input string what);
		logic last;
		int n;
		n = 0;
		last = lnk.base_clk;
		repeat (128) begin
			@(posedge CORE_CLK);
			if (lnk.base_clk !== last) n++;
			last = lnk.base_clk;
		end
		chk(what, 32'h1, {31'h0, n >= lo && n <= hi});
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial begin
		logic [7:0] d;
		repeat (3) @(posedge CORE_CLK);
		SYS_RST <= 1'b0;
		reg_chk(pcg_pkg::REG_CTRL, 8'h00, "ctrl at reset");
		reg_chk(pcg_pkg::REG_BWC, 8'h00, "bwc at reset");
		chk("acq mode at reset", 32'h1, {31'h0, acq_mode});
		reg_chk(2'h3, 8'h00, "unmapped");
		tog_chk(0, 0, "base still, osc off");
		$display("test reset done");
		sw_write(pcg_pkg::H_STAT, 8'h01);
		tog_chk(6, 9, "base from crystal");
		gen_write(pcg_pkg::REG_CTRL, 8'h04);
		reg_chk(pcg_pkg::REG_CTRL, 8'h00, "irq enable in manual");
		gen_write(pcg_pkg::REG_PROG, 8'h21);
		reg_chk(pcg_pkg::REG_PROG, 8'h21, "prog");
		chk("center freq", pcg_pkg::FNOM_HZ, center_hz);
		gen_write(pcg_pkg::REG_CTRL, 8'h01);
		gen_write(pcg_pkg::REG_BWC, 8'h04);
		stat_chk(8'h03, "early tracking refused");
		sw_write(pcg_pkg::H_STAT, 8'h03);
		repeat (ACQ_W) @(posedge CORE_CLK);
		gen_write(pcg_pkg::REG_BWC, 8'h04);
		reg_chk(pcg_pkg::REG_BWC, 8'h04, "tracking set");
		chk("acq mode off", 32'h0, {31'h0, acq_mode});
		gen_write(pcg_pkg::REG_CTRL, 8'h03);
		stat_chk(8'h03, "early vco refused");
		sw_write(pcg_pkg::H_STAT, 8'h03);
		repeat (AL_W) @(posedge CORE_CLK);
		gen_write(pcg_pkg::REG_CTRL, 8'h03);
		reg_chk(pcg_pkg::REG_CTRL, 8'h03, "vco selected");
		repeat (60) @(posedge CORE_CLK);
		tog_chk(14, 17, "base from vco");
		gen_write(pcg_pkg::REG_CTRL, 8'h02);
		reg_chk(pcg_pkg::REG_CTRL, 8'h03, "loop held on");
		gen_write(pcg_pkg::REG_CTRL, 8'h01);
		repeat (60) @(posedge CORE_CLK);
		tog_chk(6, 9, "base back on crystal");
		stat_chk(8'h01, "no irq in manual");
		gen_write(pcg_pkg::REG_CTRL, 8'h00);
		gen_write(pcg_pkg::REG_CTRL, 8'h01);
		stat_chk(8'h03, "loop on refused tracking");
		sw_write(pcg_pkg::H_STAT, 8'h03);
		$display("test manual done");
		gen_write(pcg_pkg::REG_BWC, 8'h01);
		gen_write(pcg_pkg::REG_CTRL, 8'h05);
		wait_lock(1'b1);
		reg_chk(pcg_pkg::REG_BWC, 8'h07, "auto locked");
		stat_chk(8'h0d, "irq on lock");
		gen_write(pcg_pkg::REG_CTRL, 8'h0d);
		stat_chk(8'h09, "irq cleared");
		vco_half = 250;
		wait_lock(1'b0);
		stat_chk(8'h05, "irq on unlock");
		gen_write(pcg_pkg::REG_CTRL, 8'h0f);
		stat_chk(8'h07, "vco refused unlocked");
		sw_write(pcg_pkg::H_STAT, 8'h03);
		reg_chk(pcg_pkg::REG_CTRL, 8'h0d, "crystal kept");
		gen_write(pcg_pkg::REG_CTRL, 8'h0d);
		vco_half = 100;
		wait_lock(1'b1);
		gen_write(pcg_pkg::REG_CTRL, 8'h0f);
		reg_chk(pcg_pkg::REG_CTRL, 8'h07, "vco selected locked");
		$display("test auto done");
		gen_write(pcg_pkg::REG_BWC, 8'h00);
		reg_chk(pcg_pkg::REG_CTRL, 8'h03, "irq enable dropped");
		gen_read(pcg_pkg::REG_BWC, d);
		chk("lock hidden", 32'h0, {31'h0, d[pcg_pkg::BWC_LOCK]});
		stat_chk(8'h01, "no irq after auto");
		$display("test manual return done");
		summarize();
	end
	// Hang guard
	initial begin
		repeat (60000) @(posedge CORE_CLK);
		error_cnt++;
		summarize();
	end
endmodule // pcg_tb
